/* design/sdc_pkg.sv */
package sdc_pkg;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] SDC_CTRL = 8'h00;
	localparam logic [7:0] SDC_SEGCFG = 8'h04;
	localparam logic [7:0] SDC_PFCFG = 8'h08;
	localparam logic [7:0] SDC_CMDLBA = 8'h0C;
	localparam logic [7:0] SDC_CMDLEN = 8'h10;
	localparam logic [7:0] SDC_CMDGO = 8'h14;
	localparam logic [7:0] SDC_STATUS = 8'h18;
	localparam logic [7:0] SDC_HITCNT = 8'h1C;
	// Control and status field positions
	localparam int SDC_B_READ_CACHE_DISABLE = 0;
	localparam int SDC_B_WRITE_CACHE_ENABLE = 1;
	localparam int SDC_B_DISABLE_READ_AHEAD = 2;
	localparam int SDC_B_DISC = 3;
	localparam int SDC_B_PERF_MODE = 4;
	localparam int SDC_B_CHK = 5;
	localparam int SDC_B_ILV = 6;
	localparam int SDC_B_DEFERR = 1;
	// Reset values, sizing, random-read limit and bus responses
	localparam logic [6:0] SDC_CTRL_RST = 7'h10;
	localparam logic [7:0] SDC_SEGS_DESKTOP = 8'h10;
	localparam logic [7:0] SDC_SEGS_SERVER = 8'h03;
	localparam logic [7:0] SDC_SEGS_MIN = 8'h01;
	localparam logic [7:0] SDC_SEGS_MAX = 8'h20;
	localparam int SDC_CACHE_KBYTES = 4096;
	localparam int SDC_SECTOR_BYTES = 512;
	localparam logic [15:0] SDC_CAP_SECT =
		16'(SDC_CACHE_KBYTES * 1024 / SDC_SECTOR_BYTES);
	localparam logic [2:0] SDC_RAND_LIMIT = 3'h4;
	localparam logic [1:0] SDC_OKAY = 2'h0;
	localparam logic [1:0] SDC_SLVERR = 2'h2;
	// Commands written to the go register; sequencer states
	typedef enum logic [1:0] {
		SDC_OP_READ = 2'b01,
		SDC_OP_WRITE = 2'b10,
		SDC_OP_SYNC = 2'b11
	} sdc_op_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_LOOK = 3'b001,
		ST_PF = 3'b010,
		ST_WRITE = 3'b011,
		ST_SYNC = 3'b100,
		ST_WAIT = 3'b101
	} sdc_state_e;
endpackage

/* design/sdc_cache_ctrl.sv */
// Functional notes
// - 4096 KB buffer split into logical segments
// - Cache enabled: serve read hits before media
// - Cache disabled: lookup sees prefetched data only, pass-through segments
// - Miss paced by ratio rules; hit unpaced
// - Send contiguous cached run, then fetch rest
// - First block missing: fetch all from media
// - Segments are circular, whole sectors long
// - Segment size field always reads zero
// - Size write ignored; param_check_a check rejects it
// - Segment count 1 to 32 accepted
// - Written data retained for later read hits
// - Read cache on: write clears overlapping segments before caching
// - Wrap never overwrites uncommitted data
// - Early good status; later failure deferred error
// - Synchronize commits all write data first
// - Read-ahead unless disabled; count prefetch hits
// - Limit by max prefetch; ignore ceiling
// - Cross cylinder only when discontinuity set
// - No interleave: contiguous reads keep prefetch
// - Interleave: prefetch when hit seems likely
// - Desktop fixes count; server may raise it
// - Defaults desktop mode with 16 segments
`timescale 1ns/1ps
module sdc_cache_ctrl #(
	parameter int MAX_SEG = 32,
	parameter int CYL_BLOCKS = 1024
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic mediaReq,
	output logic mediaWrite,
	output logic [31:0] mediaLba,
	output logic [15:0] mediaLen,
	output logic [4:0] mediaSeg,
	input wire logic mediaDone,
	input wire logic mediaErr,
	output logic hostSend,
	output logic [31:0] hostSendLba,
	output logic [15:0] hostSendLen,
	output logic hostPaced,
	output logic cmdDone
);
	import sdc_pkg::*;

	// ------------------------------------------------------------
	// Configuration and segment table
	// ------------------------------------------------------------
	logic [6:0] ctrl;
	logic [7:0] cfgSegs;
	logic [7:0] activeCnt;
	logic [15:0] maxPf;
	logic [15:0] pfCeiling;
	logic [31:0] cmdLba;
	logic [15:0] cmdLen;
	logic deferredErr;
	logic writeErr;
	logic lookaheadOn;
	logic [31:0] lastEnd;
	logic [2:0] randRun;
	logic [15:0] cacheHits;
	logic [15:0] pfHits;
	logic [31:0] segLba [MAX_SEG];
	logic [15:0] segCnt [MAX_SEG];
	logic [MAX_SEG-1:0] segVal;
	logic [MAX_SEG-1:0] segDirty;
	logic [MAX_SEG-1:0] segPf;
	logic [4:0] allocPtr;
	sdc_state_e state;
	sdc_state_e retState;
	sdc_op_e op;
	logic [31:0] curLba;
	logic [15:0] remain;
	logic earlyGood;

	wire readCacheDisable = ctrl[SDC_B_READ_CACHE_DISABLE];
	wire writeCacheEnable = ctrl[SDC_B_WRITE_CACHE_ENABLE];
	wire disableReadAhead = ctrl[SDC_B_DISABLE_READ_AHEAD];
	wire disc = ctrl[SDC_B_DISC];
	wire perfMode = ctrl[SDC_B_PERF_MODE];
	wire paramCheck = ctrl[SDC_B_CHK];
	wire softIlv = ctrl[SDC_B_ILV];

	// Segment length in sectors; count never zero
	wire [15:0] segLen = SDC_CAP_SECT / {8'h00, activeCnt};

	// ------------------------------------------------------------
	// Segment search over all MAX_SEG entries
	// ------------------------------------------------------------
	logic found;
	logic [4:0] hitIdx;
	logic [15:0] avail;
	logic ovlAny;
	logic [4:0] ovlIdx;
	logic dirtyAny;
	logic [4:0] dirtyIdx;
	wire [31:0] wrEnd = cmdLba + {16'h0000, cmdLen};
	// Cache disabled only sees prefetched data
	always_comb begin
		logic [31:0] segEnd;
		segEnd = 32'h0;
		found = 1'b0;
		hitIdx = 5'h00;
		avail = 16'h0000;
		ovlAny = 1'b0;
		ovlIdx = 5'h00;
		dirtyAny = 1'b0;
		dirtyIdx = 5'h00;
		for (int i = 0; i < MAX_SEG; i++) begin
			segEnd = segLba[i] + {16'h0000, segCnt[i]};
			if (segVal[i] && (!readCacheDisable || segPf[i]) &&
			    curLba >= segLba[i] && curLba < segEnd && !found) begin
				found = 1'b1;
				hitIdx = 5'(i);
				avail = 16'(segEnd - curLba);
			end
			if (segVal[i] && segLba[i] < wrEnd && segEnd > cmdLba) begin
				ovlAny = 1'b1;
				ovlIdx = 5'(i);
			end
			if (segDirty[i]) begin
				dirtyAny = 1'b1;
				dirtyIdx = 5'(i);
			end
		end
	end

	// ------------------------------------------------------------
	// Read and prefetch sizing
	// ------------------------------------------------------------
	wire [15:0] chunk = (avail < remain) ? avail : remain;
	wire [15:0] fillLen = (remain < segLen) ? remain : segLen;
	wire [31:0] pfStart = cmdLba + {16'h0000, cmdLen};
	wire [31:0] cylRoom = CYL_BLOCKS - (pfStart % CYL_BLOCKS);
	wire [15:0] pfCap = (maxPf < segLen) ? maxPf : segLen;
	// Stop at the cylinder edge unless discontinuity allows it
	wire [15:0] pfLen = (!disc && {16'h0000, pfCap} > cylRoom) ?
		cylRoom[15:0] : pfCap;
	wire pfGo = !disableReadAhead && lookaheadOn && pfLen != 16'h0000 &&
		!segDirty[allocPtr];
	wire [4:0] nextAlloc = ({3'b000, allocPtr} + 8'h01 >= activeCnt) ?
		5'h00 : allocPtr + 5'h01;
	wire contig = cmdLba == lastEnd;
	wire likely = cmdLba >= lastEnd &&
		cmdLba < lastEnd + {16'h0000, maxPf};

	// ------------------------------------------------------------
	// Register bus decode
	// ------------------------------------------------------------
	logic [7:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;
	logic awHeld;
	logic wHeld;
	wire wrFire = awHeld && wHeld && !s_axi_bvalid;
	wire [31:0] byteMask = {{8{wStrb[3]}}, {8{wStrb[2]}},
		{8{wStrb[1]}}, {8{wStrb[0]}}};
	wire [31:0] segOld = {24'h000000, cfgSegs};
	wire [31:0] segNew = (segOld & ~byteMask) | (wData & byteMask);
	wire sizeWrite = segNew[31:16] != 16'h0000;
	wire countBad = segNew[7:0] < SDC_SEGS_MIN ||
		segNew[7:0] > SDC_SEGS_MAX;
	wire segRej = (sizeWrite && paramCheck) || countBad;
	wire wrMapped = awAddr[7:5] == 3'b000 && awAddr[1:0] == 2'b00;
	wire [1:0] wrResp = (!wrMapped ||
		(awAddr == SDC_SEGCFG && segRej)) ? SDC_SLVERR : SDC_OKAY;
	wire wrOk = wrFire && wrResp == SDC_OKAY;
	wire wrGo = wrOk && awAddr == SDC_CMDGO && wStrb[0] &&
		wData[1:0] != 2'b00 && state == ST_IDLE;
	wire clrDef = wrOk && awAddr == SDC_STATUS && wStrb[0] &&
		wData[SDC_B_DEFERR];
	wire [31:0] statusWord = {18'h00000, activeCnt[5:0], 4'h0,
		lookaheadOn, writeErr, deferredErr, state != ST_IDLE};
	logic [31:0] rdMux;
	// Segment size field always reads back as zero
	always_comb begin
		if (s_axi_araddr == SDC_CTRL) begin
			rdMux = {25'h0000000, ctrl};
		end else if (s_axi_araddr == SDC_SEGCFG) begin
			rdMux = {16'h0000, 8'h00, cfgSegs};
		end else if (s_axi_araddr == SDC_PFCFG) begin
			rdMux = {pfCeiling, maxPf};
		end else if (s_axi_araddr == SDC_CMDLBA) begin
			rdMux = cmdLba;
		end else if (s_axi_araddr == SDC_CMDLEN) begin
			rdMux = {16'h0000, cmdLen};
		end else if (s_axi_araddr == SDC_STATUS) begin
			rdMux = statusWord;
		end else if (s_axi_araddr == SDC_HITCNT) begin
			rdMux = {pfHits, cacheHits};
		end else begin
			rdMux = 32'h00000000;
		end
	end
	wire rdMapped = s_axi_araddr[7:5] == 3'b000 &&
		s_axi_araddr[1:0] == 2'b00 && s_axi_araddr != SDC_CMDGO;

	// AXI4-Lite handshakes; one write and one read outstanding
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= SDC_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= SDC_OKAY;
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 8'h00;
			wData <= 32'h00000000;
			wStrb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (!awHeld && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end else if (!wHeld && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (wrFire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrResp;
				awHeld <= 1'b0;
				wHeld <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdMux;
				s_axi_rresp <= rdMapped ? SDC_OKAY : SDC_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Software settings; size field never alters segmentation
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl <= SDC_CTRL_RST;
			cfgSegs <= SDC_SEGS_DESKTOP;
			maxPf <= 16'h0000;
			pfCeiling <= 16'h0000;
			cmdLba <= 32'h00000000;
			cmdLen <= 16'h0000;
		end else if (wrOk) begin
			if (awAddr == SDC_CTRL) begin
				ctrl <= 7'(({25'h0, ctrl} & ~byteMask) |
					(wData & byteMask));
			end else if (awAddr == SDC_SEGCFG) begin
				cfgSegs <= segNew[7:0];
			end else if (awAddr == SDC_PFCFG) begin
				maxPf <= 16'({pfCeiling, maxPf} & ~byteMask |
					wData & byteMask);
				pfCeiling <= 16'(({pfCeiling, maxPf} & ~byteMask |
					wData & byteMask) >> 16);
			end else if (awAddr == SDC_CMDLBA) begin
				cmdLba <= (cmdLba & ~byteMask) | (wData & byteMask);
			end else if (awAddr == SDC_CMDLEN) begin
				cmdLen <= 16'((cmdLen & ~byteMask[15:0]) |
					(wData[15:0] & byteMask[15:0]));
			end
		end
	end

	// Desktop mode holds the count; server mode grows on random reads
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			activeCnt <= SDC_SEGS_DESKTOP;
		end else if (perfMode || activeCnt < cfgSegs) begin
			activeCnt <= cfgSegs;
		end else if (randRun == SDC_RAND_LIMIT &&
		             activeCnt < SDC_SEGS_MAX && state == ST_IDLE) begin
			activeCnt <= activeCnt + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			retState <= ST_IDLE;
			op <= SDC_OP_READ;
			curLba <= 32'h00000000;
			remain <= 16'h0000;
			earlyGood <= 1'b0;
			mediaReq <= 1'b0;
			mediaWrite <= 1'b0;
			mediaLba <= 32'h00000000;
			mediaLen <= 16'h0000;
			mediaSeg <= 5'h00;
			hostSend <= 1'b0;
			hostSendLba <= 32'h00000000;
			hostSendLen <= 16'h0000;
			hostPaced <= 1'b0;
			cmdDone <= 1'b0;
			deferredErr <= 1'b0;
			writeErr <= 1'b0;
			lookaheadOn <= 1'b0;
			lastEnd <= 32'h00000000;
			randRun <= 3'h0;
			cacheHits <= 16'h0000;
			pfHits <= 16'h0000;
			segVal <= '0;
			segDirty <= '0;
			segPf <= '0;
			allocPtr <= 5'h00;
			for (int i = 0; i < MAX_SEG; i++) begin
				segLba[i] <= 32'h00000000;
				segCnt[i] <= 16'h0000;
			end
		end else begin
			hostSend <= 1'b0;
			cmdDone <= 1'b0;
			// A media failure wins over a clearing write
			if (clrDef) begin
				deferredErr <= 1'b0;
			end
			case (state)
			ST_IDLE: begin
				if (wrGo) begin
					op <= sdc_op_e'(wData[1:0]);
					curLba <= cmdLba;
					remain <= cmdLen;
					writeErr <= 1'b0;
					earlyGood <= 1'b0;
					if (wData[1:0] == SDC_OP_READ) begin
						state <= ST_LOOK;
						lastEnd <= pfStart;
						lookaheadOn <= softIlv ? likely : contig;
						randRun <= contig ? 3'h0 :
							(randRun == SDC_RAND_LIMIT ? randRun :
							randRun + 3'h1);
					end else if (wData[1:0] == SDC_OP_WRITE) begin
						state <= ST_WRITE;
					end else begin
						state <= ST_SYNC;
					end
				end
			end
			ST_LOOK: begin
				if (remain == 16'h0000) begin
					state <= ST_PF;
				end else if (found) begin
					// Unpaced hit, possibly spread over segments
					hostSend <= 1'b1;
					hostSendLba <= curLba;
					hostSendLen <= chunk;
					hostPaced <= 1'b0;
					curLba <= curLba + {16'h0000, chunk};
					remain <= remain - chunk;
					if (segPf[hitIdx]) begin
						pfHits <= pfHits + 16'h0001;
					end else begin
						cacheHits <= cacheHits + 16'h0001;
					end
				end else if (segDirty[allocPtr]) begin
					// Never reuse a segment with uncommitted data
					mediaReq <= 1'b1;
					mediaWrite <= 1'b1;
					mediaLba <= segLba[allocPtr];
					mediaLen <= segCnt[allocPtr];
					mediaSeg <= allocPtr;
					retState <= ST_LOOK;
					state <= ST_WAIT;
				end else begin
					// Fetch the rest into one circular segment
					segVal[allocPtr] <= 1'b1;
					segPf[allocPtr] <= 1'b0;
					segLba[allocPtr] <= curLba;
					segCnt[allocPtr] <= fillLen;
					allocPtr <= nextAlloc;
					mediaReq <= 1'b1;
					mediaWrite <= 1'b0;
					mediaLba <= curLba;
					mediaLen <= remain;
					mediaSeg <= allocPtr;
					hostSend <= 1'b1;
					hostSendLba <= curLba;
					hostSendLen <= remain;
					hostPaced <= 1'b1;
					remain <= 16'h0000;
					retState <= ST_PF;
					state <= ST_WAIT;
				end
			end
			ST_PF: begin
				cmdDone <= 1'b1;
				state <= ST_IDLE;
				if (pfGo) begin
					// Read ahead beyond the request
					segVal[allocPtr] <= 1'b1;
					segPf[allocPtr] <= 1'b1;
					segLba[allocPtr] <= pfStart;
					segCnt[allocPtr] <= pfLen;
					allocPtr <= nextAlloc;
					mediaReq <= 1'b1;
					mediaWrite <= 1'b0;
					mediaLba <= pfStart;
					mediaLen <= pfLen;
					mediaSeg <= allocPtr;
					retState <= ST_IDLE;
					state <= ST_WAIT;
				end
			end
			ST_WRITE: begin
				if (!readCacheDisable && ovlAny && !segDirty[ovlIdx]) begin
					segVal[ovlIdx] <= 1'b0;
				end else if ((!readCacheDisable && ovlAny) ||
				             segDirty[allocPtr]) begin
					// Commit older data before it is replaced
					mediaReq <= 1'b1;
					mediaWrite <= 1'b1;
					mediaLba <= segLba[ovlAny ? ovlIdx : allocPtr];
					mediaLen <= segCnt[ovlAny ? ovlIdx : allocPtr];
					mediaSeg <= ovlAny ? ovlIdx : allocPtr;
					retState <= ST_WRITE;
					state <= ST_WAIT;
				end else begin
					// New data stays cached for later hits
					segVal[allocPtr] <= 1'b1;
					segPf[allocPtr] <= 1'b0;
					segLba[allocPtr] <= cmdLba;
					segCnt[allocPtr] <= fillLen;
					segDirty[allocPtr] <= 1'b1;
					allocPtr <= nextAlloc;
					if (writeCacheEnable && remain <= segLen) begin
						// Good status once the data sits in cache
						cmdDone <= 1'b1;
						state <= ST_IDLE;
					end else begin
						// Write cache off, or wrapping would overrun unwritten data
						earlyGood <= 1'b0;
						mediaReq <= 1'b1;
						mediaWrite <= 1'b1;
						mediaLba <= cmdLba;
						mediaLen <= remain;
						mediaSeg <= allocPtr;
						retState <= ST_IDLE;
						state <= ST_WAIT;
					end
				end
			end
			ST_SYNC: begin
				if (dirtyAny) begin
					// Flush every dirty segment before completing
					earlyGood <= 1'b1;
					mediaReq <= 1'b1;
					mediaWrite <= 1'b1;
					mediaLba <= segLba[dirtyIdx];
					mediaLen <= segCnt[dirtyIdx];
					mediaSeg <= dirtyIdx;
					retState <= ST_SYNC;
					state <= ST_WAIT;
				end else begin
					cmdDone <= 1'b1;
					state <= ST_IDLE;
				end
			end
			ST_WAIT: begin
				if (mediaDone) begin
					mediaReq <= 1'b0;
					state <= retState;
					if (mediaWrite) begin
						segDirty[mediaSeg] <= 1'b0;
						if (readCacheDisable && !mediaErr) begin
							segVal[mediaSeg] <= 1'b0;
						end
						if (mediaErr && (earlyGood || op != SDC_OP_WRITE
						    || retState != ST_IDLE)) begin
							deferredErr <= 1'b1;
						end else if (mediaErr) begin
							writeErr <= 1'b1;
						end
					end
					if (retState == ST_IDLE && op != SDC_OP_READ) begin
						cmdDone <= 1'b1;
					end
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_size_reads_zero: assert property (@(posedge ref_clk)
		disable iff (sys_rst)
		$rose(s_axi_rvalid) && $past(s_axi_araddr) == SDC_SEGCFG
		|-> s_axi_rdata[31:16] == 16'h0000)
		else $error("segment size field read nonzero");
	a_param_check_a_reject: assert property (@(posedge ref_clk)
		disable iff (sys_rst)
		wrFire && awAddr == SDC_SEGCFG && sizeWrite && paramCheck
		|=> s_axi_bvalid && s_axi_bresp == SDC_SLVERR && $stable(cfgSegs))
		else $error("param_check_a size write not rejected");
	a_count_range: assert property (@(posedge ref_clk)
		disable iff (sys_rst)
		activeCnt >= SDC_SEGS_MIN && activeCnt <= SDC_SEGS_MAX)
		else $error("segment count out of range");
	a_desktop_fixed: assert property (@(posedge ref_clk)
		disable iff (sys_rst)
		perfMode ##1 perfMode && $stable(cfgSegs)
		|-> activeCnt == cfgSegs)
		else $error("desktop mode count drifted");
	a_hit_unpaced: assert property (@(posedge ref_clk)
		disable iff (sys_rst)
		state == ST_LOOK && found && remain != 16'h0000
		|=> hostSend && !hostPaced && !$rose(mediaReq))
		else $error("cache hit not served from buffer");
	a_sync_clean: assert property (@(posedge ref_clk)
		disable iff (sys_rst)
		state == ST_SYNC ##1 cmdDone |-> !dirtyAny)
		else $error("sync completed with dirty data");
	a_pf_limit: assert property (@(posedge ref_clk)
		disable iff (sys_rst)
		$rose(mediaReq) && $past(state) == ST_PF
		|-> mediaLen <= maxPf && !disableReadAhead)
		else $error("prefetch exceeds limit or disabled");
	a_deferred_err: assert property (@(posedge ref_clk)
		disable iff (sys_rst)
		state == ST_WAIT && mediaDone && mediaErr && mediaWrite
		&& earlyGood |=> deferredErr [*2])
		else $error("deferred error not raised");
endmodule

/* verif/sdc_media_model.sv */
`timescale 1ns/1ps
// Media channel stand-in: answers each request after mDly cycles
module sdc_media_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic mediaReq,
	input wire logic mediaWrite,
	input wire logic [7:0] mDly,
	input wire logic mFail,
	output logic mediaDone,
	output logic mediaErr,
	output int nRd,
	output int nWr
);
	logic [7:0] waitCnt;
	// ----------------------------------------
	// Answer logic
	// ----------------------------------------
	// Error flag toggles when idle so no stale level reads as valid
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mediaDone <= 1'b0;
			mediaErr <= 1'b0;
			waitCnt <= 8'h00;
			nRd <= 0;
			nWr <= 0;
		end else if (mediaDone) begin
			mediaDone <= 1'b0;
			mediaErr <= ~mediaErr;
			waitCnt <= 8'h00;
		end else if (mediaReq && waitCnt >= mDly) begin
			mediaDone <= 1'b1;
			mediaErr <= mFail & mediaWrite;
			if (mediaWrite) begin
				nWr <= nWr + 1;
			end else begin
				nRd <= nRd + 1;
			end
		end else begin
			mediaErr <= ~mediaErr;
			if (mediaReq) begin
				waitCnt <= waitCnt + 8'h01;
			end
		end
	end
endmodule

/* verif/tb_segmented_disk_buffer_cache.sv */
`timescale 1ns/1ps
module tb_segmented_disk_buffer_cache;
	import sdc_pkg::*;
	logic ref_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, mediaReq, mediaWrite;
	logic mediaDone, mediaErr, hostSend, hostPaced, cmdDone, mFail, sPaced;
	logic [7:0] s_axi_awaddr, s_axi_araddr, mDly;
	logic [31:0] s_axi_wdata, s_axi_rdata, mediaLba, hostSendLba, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [15:0] mediaLen, hostSendLen, sBase;
	logic [15:0] sSum = 16'h0000;
	logic [4:0] mediaSeg;
	int n_errors, compares, nRd, nWr, nDone, wrAtDone, r0, i;
	sdc_cache_ctrl u_dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .mediaReq(mediaReq),
		.mediaWrite(mediaWrite), .mediaLba(mediaLba),
		.mediaLen(mediaLen), .mediaSeg(mediaSeg),
		.mediaDone(mediaDone), .mediaErr(mediaErr),
		.hostSend(hostSend), .hostSendLba(hostSendLba),
		.hostSendLen(hostSendLen), .hostPaced(hostPaced),
		.cmdDone(cmdDone)
	);
	sdc_media_model u_media (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .mediaReq(mediaReq),
		.mediaWrite(mediaWrite), .mDly(mDly), .mFail(mFail),
		.mediaDone(mediaDone), .mediaErr(mediaErr), .nRd(nRd), .nWr(nWr)
	);
	// ----------------------------------------
	// Clock, monitors, watchdog
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Hit transfers arrive in chunks, so lengths are summed
	always @(posedge ref_clk) begin
		if (hostSend) begin
			sSum = sSum + hostSendLen;
			sPaced = hostPaced;
		end
		if (cmdDone) begin
			nDone++;
			wrAtDone = nWr;
		end
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		wrap_up();
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		if (n_errors == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rdr(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge ref_clk);
	endtask
	// Issue a command; wt waits for its completion pulse
	task automatic cmd(input logic [1:0] op, input logic [31:0] lba,
			input logic [31:0] len, input bit wt);
		int k;
		k = nDone;
		sBase = sSum;
		r0 = nRd;
		wr(SDC_CMDLBA, lba);
		wr(SDC_CMDLEN, len);
		wr(SDC_CMDGO, {30'h0, op});
		while (wt && nDone == k) @(posedge ref_clk);
	endtask
	// Poll status until the sequencer is idle; prefetch keeps it busy
	task automatic wait_idle();
		rd = 32'h1;
		for (i = 0; i < 200 && rd[0] !== 1'b0; i++) rdr(SDC_STATUS);
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, mFail} = 3'h0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		mDly = 8'h03;
		sys_rst = 1'b1;
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rdr(SDC_CTRL);
		chk(rd, 32'h10);
		rdr(SDC_SEGCFG);
		chk(rd, 32'h10);
		rdr(SDC_STATUS);
		chk(rd & 32'h3F00, 32'h1000);
		wr(8'h20, 32'h1);
		chk(rs, SDC_SLVERR);
		// Count boundaries: 0 and 33 refused, 1 and 32 taken
		for (i = 0; i < 4; i++) begin
			wr(SDC_SEGCFG, (i < 2) ? i : i + 30);
			chk(rs, (i == 1 || i == 2) ? SDC_OKAY : SDC_SLVERR);
		end
		wr(SDC_SEGCFG, 32'h0040_0004);
		rdr(SDC_SEGCFG);
		chk(rd, 32'h4);
		wr(SDC_CTRL, 32'h30);
		wr(SDC_SEGCFG, 32'h0040_0008);
		chk(rs, SDC_SLVERR);
		rdr(SDC_SEGCFG);
		chk(rd, 32'h4);
		wr(SDC_CTRL, 32'h10);
		cmd(SDC_OP_READ, 32'h100, 4, 1);
		chk(nRd - r0, 1);
		chk({sPaced, 16'(sSum - sBase)}, {1'b1, 16'h4});
		mDly <= 8'h14;
		cmd(SDC_OP_READ, 32'h100, 4, 1);
		chk(nRd - r0, 0);
		chk({sPaced, 16'(sSum - sBase)}, {1'b0, 16'h4});
		rdr(SDC_HITCNT);
		chk(rd & 32'hFFFF, 32'h1);
		wr(SDC_CTRL, 32'h11);
		cmd(SDC_OP_READ, 32'h100, 4, 1);
		chk(nRd - r0, 1);
		wr(SDC_CTRL, 32'h10);
		cmd(SDC_OP_WRITE, 32'h100, 2, 1);
		chk(wrAtDone, 1);
		// Stale copies beyond the written blocks must miss
		cmd(SDC_OP_READ, 32'h100, 4, 1);
		chk(nRd - r0, 1);
		chk({sPaced, 16'(sSum - sBase)}, {1'b1, 16'h4});
		rdr(SDC_HITCNT);
		chk(rd & 32'hFFFF, 32'h2);
		wr(SDC_CTRL, 32'h12);
		cmd(SDC_OP_WRITE, 32'h200, 2, 1);
		chk(wrAtDone, 1);
		cmd(SDC_OP_SYNC, 0, 0, 1);
		chk(wrAtDone, 2);
		mFail <= 1'b1;
		cmd(SDC_OP_WRITE, 32'h300, 1, 1);
		cmd(SDC_OP_SYNC, 0, 0, 0);
		wait_idle();
		chk(rd[1], 1'b1);
		mFail <= 1'b0;
		wr(SDC_STATUS, 32'h2);
		rdr(SDC_STATUS);
		chk(rd[1], 1'b0);
		// Read-ahead: only a contiguous follow-up turns it on
		wr(SDC_PFCFG, 32'h0000_0008);
		cmd(SDC_OP_READ, 32'h500, 2, 1);
		wait_idle();
		chk(rd[3], 1'b0);
		chk(nRd - r0, 1);
		cmd(SDC_OP_READ, 32'h502, 2, 1);
		wait_idle();
		chk(rd[3], 1'b1);
		chk(nRd - r0, 2);
		cmd(SDC_OP_READ, 32'h504, 4, 1);
		chk(nRd - r0, 0);
		rdr(SDC_HITCNT);
		chk(rd[31:16], 32'h1);
		wrap_up();
	end
endmodule
